// ### inc/rrs_pkg.sv
`default_nettype none
package rrs_pkg;
  // instruction encodings
  localparam int          INSTR_W        = 12;
  localparam logic [5:0]  ROT_OPCODE     = 6'h0C;
  localparam int          ROT_OPC_MSB    = 11;
  localparam int          ROT_OPC_LSB    = 6;
  localparam int          ROT_DEST_BIT   = 5;
  localparam int          ROT_FIDX_MSB   = 4;
  localparam logic [11:0] SLEEP_WORD     = 12'h003;

  // data path
  localparam int          DATA_W         = 8;
  localparam int          FILE_DEPTH     = 32;
  localparam int          FIDX_W         = 5;

  // register bus map
  localparam int          ADDR_W         = 6;
  localparam logic [5:0]  ADDR_FILE_TOP  = 6'h1F;
  localparam logic [5:0]  ADDR_ACCUM     = 6'h20;
  localparam logic [5:0]  ADDR_STATUS    = 6'h21;
  localparam logic [5:0]  ADDR_IRQ_STAT  = 6'h22;
  localparam logic [5:0]  ADDR_IRQ_MASK  = 6'h23;
  localparam logic [5:0]  ADDR_WDOG      = 6'h24;
  localparam logic [5:0]  ADDR_PRESCALE  = 6'h25;
  localparam logic [5:0]  ADDR_CONTROL   = 6'h26;

  // status register fields
  localparam int          ST_CARRY       = 0;
  localparam int          ST_POWERDOWN   = 3;
  localparam int          ST_TIMEOUT     = 4;
  localparam int          ST_PIN_WAKE    = 7;

  // control register fields
  localparam int          CTL_SOFT_WAKE  = 0;

  // interrupt status fields
  localparam int          IRQ_W          = 3;
  localparam int          IRQ_ROTATE     = 0;
  localparam int          IRQ_SLEEP      = 1;
  localparam int          IRQ_WAKE       = 2;

  // reset values
  localparam logic        RST_CARRY      = 1'b0;
  localparam logic        RST_TIMEOUT    = 1'b1;
  localparam logic        RST_POWERDOWN  = 1'b1;
  localparam logic        RST_PIN_WAKE   = 1'b0;
  localparam logic [7:0]  RST_BYTE       = 8'h00;
  localparam logic [2:0]  RST_IRQ        = 3'h0;

  // watchdog sizing
  localparam int          WDOG_W         = 8;
  localparam int          PRESCALE_W     = 8;

  typedef enum logic [0:0] {
    CORE_RUN   = 1'b0,
    CORE_SLEEP = 1'b1
  } core_state_t;
endpackage : rrs_pkg
`default_nettype wire

// ### rtl/rotate_right_through_carry.sv
`default_nettype none
module rotate_right_through_carry
  import rrs_pkg::*;
#(
  parameter int WIDTH = DATA_W
) (
  input  wire logic [WIDTH-1:0] operand,
  input  wire logic             carry_in,
  output logic      [WIDTH-1:0] result,
  output logic                  carry_out
);
  // old carry lands in the msb, old lsb leaves as carry
  assign result    = {carry_in, operand[WIDTH-1:1]}; // [RULE1]
  assign carry_out = operand[0];                     // [RULE1]
endmodule : rotate_right_through_carry
`default_nettype wire

// ### rtl/rotate_and_sleep_execute.sv
// Notes on behaviour
// [RULE1] rotate right: old carry to msb, old lsb to carry; no other flag
// [RULE2] destination bit zero: result to accumulator, file register kept
// [RULE3] destination bit one: result written back to the source file register
// [RULE4] rotate decoded as 0011 00, destination bit, 5-bit register index
// [RULE5] low-power entry sets the timeout status flag
// [RULE6] low-power entry clears power-down flag, pin-change wake flag kept
// [RULE7] low-power entry zeroes the watchdog counter and its prescaler
// [RULE8] after low-power entry oscillator halts; no instructions until wake
// [RULE9] low-power entry is 0000 0000 0011; both instructions take one cycle
//
// Added by the designer: the plain strobed port and the placing of the registers.
`default_nettype none
module rotate_and_sleep_execute
  import rrs_pkg::*;
#(
  parameter int WDOG_BITS     = WDOG_W,
  parameter int PRESCALE_BITS = PRESCALE_W
) (
  input  wire logic               clk,
  input  wire logic               rst_b,
  // instruction stream
  input  wire logic [INSTR_W-1:0] instr,
  input  wire logic               instr_valid,
  output logic                    instr_ready,
  output logic                    osc_run,
  // wake-up sources
  input  wire logic               pin_change,
  // register port
  input  wire logic [ADDR_W-1:0]  reg_addr,
  input  wire logic [DATA_W-1:0]  reg_wdata,
  input  wire logic               reg_write,
  input  wire logic               reg_read,
  output logic      [DATA_W-1:0]  reg_rdata,
  output logic                    irq
);

  ////////////////////////////////////////////////////////////////////////////
  // storage

  logic [DATA_W-1:0]        file_q [FILE_DEPTH];
  logic [DATA_W-1:0]        accum_q;
  logic                     carry_q;
  logic                     timeout_status_flag_q;
  logic                     powerdown_status_flag_q;
  logic                     pin_change_wake_flag_q;
  logic [WDOG_BITS-1:0]     watchdog_counter_q;
  logic [PRESCALE_BITS-1:0] prescale_q;
  logic [IRQ_W-1:0]         irq_stat_q;
  logic [IRQ_W-1:0]         irq_mask_q;
  logic [DATA_W-1:0]        reg_rdata_q;
  core_state_t              state_q;
  core_state_t              state_d;

  ////////////////////////////////////////////////////////////////////////////
  // decode

  logic              exec;
  logic              is_rotate;
  logic              is_sleep;
  logic              rot_to_file;
  logic [FIDX_W-1:0] rot_idx;
  logic [DATA_W-1:0] rot_operand;
  logic [DATA_W-1:0] rot_result;
  logic              rot_carry;

  // the core only accepts words while the oscillator runs
  assign instr_ready = (state_q == CORE_RUN);                 // [RULE8]
  assign osc_run     = (state_q == CORE_RUN);                 // [RULE8]
  assign exec        = instr_valid && instr_ready;            // [RULE9]

  assign is_rotate   = exec &&                                // [RULE4]
                       (instr[ROT_OPC_MSB:ROT_OPC_LSB] == ROT_OPCODE);
  assign is_sleep    = exec && (instr == SLEEP_WORD);         // [RULE9]
  assign rot_to_file = instr[ROT_DEST_BIT];                   // [RULE4]
  assign rot_idx     = instr[ROT_FIDX_MSB:0];                 // [RULE4]
  assign rot_operand = file_q[rot_idx];

  rotate_right_through_carry #(
    .WIDTH     (DATA_W)
  ) u_rotate (
    .operand   (rot_operand),
    .carry_in  (carry_q),
    .result    (rot_result),
    .carry_out (rot_carry)
  );

  ////////////////////////////////////////////////////////////////////////////
  // register port decode

  // one strobe per register keeps every update process short
  logic bus_file;
  logic wr_accum;
  logic wr_status;
  logic wr_irq_stat;
  logic wr_irq_mask;
  logic wr_control;
  logic soft_wake;
  logic wake;

  assign bus_file    = (reg_addr <= ADDR_FILE_TOP);
  assign wr_accum    = reg_write && (reg_addr == ADDR_ACCUM);
  assign wr_status   = reg_write && (reg_addr == ADDR_STATUS);
  assign wr_irq_stat = reg_write && (reg_addr == ADDR_IRQ_STAT);
  assign wr_irq_mask = reg_write && (reg_addr == ADDR_IRQ_MASK);
  assign wr_control  = reg_write && (reg_addr == ADDR_CONTROL);
  // a wake write while running is harmless and ignored
  assign soft_wake   = wr_control && reg_wdata[CTL_SOFT_WAKE];
  assign wake        = (state_q == CORE_SLEEP) && (pin_change || soft_wake);

  ////////////////////////////////////////////////////////////////////////////
  // file registers: instruction write-back wins over a bus write

  genvar gi;
  generate
    for (gi = 0; gi < FILE_DEPTH; gi++) begin : g_file
      always_ff @(posedge clk) begin
        if (!rst_b) begin
          file_q[gi] <= RST_BYTE;
        end else if (is_rotate && rot_to_file &&
                     rot_idx == FIDX_W'(gi)) begin
          file_q[gi] <= rot_result;                           // [RULE3]
        end else if (reg_write && bus_file &&
                     reg_addr == ADDR_W'(gi)) begin
          file_q[gi] <= reg_wdata;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // accumulator
  // sleep leaves it as it was; only a rotate or a write changes it

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      accum_q <= RST_BYTE;
    end else if (is_rotate && !rot_to_file) begin
      accum_q <= rot_result;                                  // [RULE2]
    end else if (wr_accum) begin
      accum_q <= reg_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // carry: the rotate touches no other status bit

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      carry_q <= RST_CARRY;
    end else if (is_rotate) begin
      carry_q <= rot_carry;                                   // [RULE1]
    end else if (wr_status) begin
      carry_q <= reg_wdata[ST_CARRY];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // timeout flag

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      timeout_status_flag_q <= RST_TIMEOUT;
    end else if (is_sleep) begin
      timeout_status_flag_q <= 1'b1;                          // [RULE5]
    end else if (wr_status) begin
      timeout_status_flag_q <= reg_wdata[ST_TIMEOUT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // power-down flag: sleep entry beats a status write in the same cycle

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      powerdown_status_flag_q <= RST_POWERDOWN;
    end else if (is_sleep) begin
      powerdown_status_flag_q <= 1'b0;                        // [RULE6]
    end else if (wr_status) begin
      powerdown_status_flag_q <= reg_wdata[ST_POWERDOWN];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin-change wake flag: sleep entry leaves it alone

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pin_change_wake_flag_q <= RST_PIN_WAKE;
    end else if ((state_q == CORE_SLEEP) && pin_change) begin
      pin_change_wake_flag_q <= 1'b1;
    end else if (wr_status) begin
      pin_change_wake_flag_q <= reg_wdata[ST_PIN_WAKE];       // [RULE6]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // watchdog prescaler and counter
  // the counter only shows time; the timeout action itself lives elsewhere

  logic prescale_wrap;

  assign prescale_wrap = (prescale_q == {PRESCALE_BITS{1'b1}});

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      prescale_q <= '0;
    end else if (is_sleep) begin
      prescale_q <= '0;                                       // [RULE7]
    end else if (state_q == CORE_RUN) begin
      prescale_q <= prescale_q + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      watchdog_counter_q <= '0;
    end else if (is_sleep) begin
      watchdog_counter_q <= '0;                               // [RULE7]
    end else if (state_q == CORE_RUN && prescale_wrap) begin
      watchdog_counter_q <= watchdog_counter_q + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // run / sleep state

  always_comb begin
    state_d = state_q;
    case (state_q)
      CORE_RUN: begin
        if (is_sleep) begin
          state_d = CORE_SLEEP;                               // [RULE8]
        end
      end
      CORE_SLEEP: begin
        if (wake) begin
          state_d = CORE_RUN;
        end
      end
      default: begin
        state_d = CORE_RUN;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_q <= CORE_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupts: a new event beats a write-one-to-clear in the same cycle

  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] irq_clr;

  always_comb begin
    irq_set             = '0;
    irq_set[IRQ_ROTATE] = is_rotate;
    irq_set[IRQ_SLEEP]  = is_sleep;
    irq_set[IRQ_WAKE]   = wake;
  end

  assign irq_clr = wr_irq_stat ?
                   reg_wdata[IRQ_W-1:0] : '0;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      irq_stat_q <= RST_IRQ;
    end else begin
      irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      irq_mask_q <= RST_IRQ;
    end else if (wr_irq_mask) begin
      irq_mask_q <= reg_wdata[IRQ_W-1:0];
    end
  end

  assign irq = |(irq_stat_q & irq_mask_q);

  ////////////////////////////////////////////////////////////////////////////
  // read data, one cycle after the strobe, zero otherwise

  logic [DATA_W-1:0] rd_mux;

  always_comb begin
    rd_mux = RST_BYTE;
    if (bus_file) begin
      rd_mux = file_q[reg_addr[FIDX_W-1:0]];
    end else begin
      case (reg_addr)
        ADDR_ACCUM: begin
          rd_mux = accum_q;
        end
        ADDR_STATUS: begin
          rd_mux[ST_CARRY]     = carry_q;
          rd_mux[ST_POWERDOWN] = powerdown_status_flag_q;
          rd_mux[ST_TIMEOUT]   = timeout_status_flag_q;
          rd_mux[ST_PIN_WAKE]  = pin_change_wake_flag_q;
        end
        ADDR_IRQ_STAT: begin
          rd_mux[IRQ_W-1:0] = irq_stat_q;
        end
        ADDR_IRQ_MASK: begin
          rd_mux[IRQ_W-1:0] = irq_mask_q;
        end
        ADDR_WDOG: begin
          rd_mux = DATA_W'(watchdog_counter_q);
        end
        ADDR_PRESCALE: begin
          rd_mux = DATA_W'(prescale_q);
        end
        ADDR_CONTROL: begin
          rd_mux[CTL_SOFT_WAKE] = (state_q == CORE_SLEEP);
        end
        // unmapped addresses read as zero
        default: begin
          rd_mux = RST_BYTE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      reg_rdata_q <= RST_BYTE;
    end else if (reg_read) begin
      reg_rdata_q <= rd_mux;
    end else begin
      reg_rdata_q <= RST_BYTE;
    end
  end

  assign reg_rdata = reg_rdata_q;

endmodule : rotate_and_sleep_execute
`default_nettype wire

// ### testbench/rotate_and_sleep_execute_props.sv
`default_nettype none
module rotate_and_sleep_execute_props
  import rrs_pkg::*;
#(
  parameter int WDOG_BITS     = WDOG_W,
  parameter int PRESCALE_BITS = PRESCALE_W
) (
  input wire logic               clk,
  input wire logic               rst_b,
  input wire logic [INSTR_W-1:0] instr,
  input wire logic               instr_valid,
  input wire logic               instr_ready,
  input wire logic               osc_run,
  input wire logic               pin_change,
  input wire logic [ADDR_W-1:0]  reg_addr,
  input wire logic [DATA_W-1:0]  reg_wdata,
  input wire logic               reg_write,
  input wire logic               reg_read,
  input wire logic [DATA_W-1:0]  reg_rdata,
  input wire logic               irq
);
  timeunit 1ns;
  timeprecision 1ns;

  logic              take;
  logic              rot;
  logic              slp;
  logic              wake_req;
  logic [DATA_W-1:0] rd1_q;
  logic [DATA_W-1:0] rd2_q;

  assign take = instr_valid && instr_ready;
  assign rot = take && (instr[ROT_OPC_MSB:ROT_OPC_LSB] == ROT_OPCODE);
  assign slp = take && (instr == SLEEP_WORD);
  assign wake_req = pin_change || (reg_write && reg_addr == ADDR_CONTROL
                    && reg_wdata[CTL_SOFT_WAKE]);

  // read data two cycles back, to compare a file register around a rotate
  always_ff @(posedge clk) begin
    rd1_q <= reg_rdata;
    rd2_q <= rd1_q;
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  // read of a file reg, rotate on it, read it again
  sequence rot_seq(logic dst);
    (reg_read && reg_addr <= ADDR_FILE_TOP) ##1
    (rot && instr[ROT_DEST_BIT] == dst && !reg_write &&
     {1'b0, instr[ROT_FIDX_MSB:0]} == $past(reg_addr)) ##1
    (reg_read && reg_addr == $past(reg_addr, 2));
  endsequence

  sleep_halt_a: assert property (slp |=> !instr_ready)
    else $error("core still runs after low-power entry");
  osc_follow_a: assert property (osc_run == instr_ready)
    else $error("oscillator state differs from core state");
  rotate_runs_a: assert property (rot |=> instr_ready)
    else $error("rotate stopped the core");
  asleep_hold_a: assert property
    (!instr_ready && !wake_req |=> !instr_ready)
    else $error("core woke without a wake-up event");
  keep_file_a: assert property
    (rot_seq(1'b0) |=> reg_rdata == rd2_q)
    else $error("rotate to accumulator changed the file register");
  write_back_a: assert property
    (rot_seq(1'b1) |=> reg_rdata[6:0] == rd2_q[7:1])
    else $error("rotated value not written back");
  sleep_status_a: assert property
    (slp ##1 (reg_read && reg_addr == ADDR_STATUS) |=>
     reg_rdata[ST_TIMEOUT] && !reg_rdata[ST_POWERDOWN])
    else $error("status flags wrong after low-power entry");
  wdog_clear_a: assert property
    (slp ##[1:8] (reg_read && reg_addr == ADDR_WDOG && !instr_ready) |=>
     reg_rdata == 8'h00)
    else $error("watchdog counter not cleared");
  prescale_clear_a: assert property
    (slp ##[1:8] (reg_read && reg_addr == ADDR_PRESCALE && !instr_ready) |=>
     reg_rdata == 8'h00)
    else $error("prescaler not cleared");
endmodule : rotate_and_sleep_execute_props
`default_nettype wire

// ### testbench/rotate_and_sleep_execute_bench.sv
`default_nettype none
module rotate_and_sleep_execute_bench
  import rrs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic               clk;
  logic               rst_b;
  logic [INSTR_W-1:0] instr;
  logic               instr_valid;
  logic               instr_ready;
  logic               osc_run;
  logic               pin_change;
  logic [ADDR_W-1:0]  reg_addr;
  logic [DATA_W-1:0]  reg_wdata;
  logic               reg_write;
  logic               reg_read;
  logic [DATA_W-1:0]  reg_rdata;
  logic               irq;
  int                 n_errors;
  int                 comparisons;

  rotate_and_sleep_execute dut_u (
    .clk(clk), .rst_b(rst_b), .instr(instr), .instr_valid(instr_valid),
    .instr_ready(instr_ready), .osc_run(osc_run), .pin_change(pin_change),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .irq(irq)
  );

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task report_and_stop;
    if (n_errors == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : report_and_stop

  task chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // one bus/instruction cycle, driven just after the edge
  task cyc(input logic w, input logic r, input logic [5:0] a,
           input logic [7:0] d, input logic iv, input logic [11:0] i);
    @(posedge clk);
    reg_write   <= w;
    reg_read    <= r;
    reg_addr    <= a;
    reg_wdata   <= d;
    instr_valid <= iv;
    instr       <= i;
  endtask : cyc

  task settle;
    cyc(1'b0, 1'b0, 6'h00, 8'h00, 1'b0, 12'h000);
    #1;
  endtask : settle

  task wr(input logic [5:0] a, input logic [7:0] d);
    cyc(1'b1, 1'b0, a, d, 1'b0, 12'h000);
  endtask : wr

  task rd(input logic [5:0] a);
    cyc(1'b0, 1'b1, a, 8'h00, 1'b0, 12'h000);
  endtask : rd

  task ins(input logic [11:0] i);
    cyc(1'b0, 1'b0, 6'h00, 8'h00, 1'b1, i);
  endtask : ins

  // read data only stands in the cycle after the strobe
  task rd_chk(input logic [5:0] a, input logic [7:0] exp);
    rd(a);
    settle;
    chk(reg_rdata, exp);
  endtask : rd_chk

  ////////////////////////////////////////////////////////////////////////////
  task test_rotate;
    wr(6'h05, 8'hA5);
    wr(ADDR_STATUS, 8'h19);
    rd(6'h05);
    ins(12'h325);
    rd_chk(6'h05, 8'hD2);
    rd_chk(ADDR_STATUS, 8'h19);
    rd(6'h05);
    ins(12'h305);
    rd_chk(6'h05, 8'hD2);
    rd_chk(ADDR_ACCUM, 8'hE9);
    rd_chk(ADDR_STATUS, 8'h18);
    wr(6'h1F, 8'h01);
    ins(12'h33F);
    ins(12'h33F);
    rd_chk(6'h1F, 8'h80);
    ins(12'h385);
    rd_chk(ADDR_ACCUM, 8'hE9);
  endtask : test_rotate

  task test_sleep;
    // run long enough for the prescaler to wrap into the watchdog
    repeat (260) @(posedge clk);
    wr(ADDR_STATUS, 8'h81);
    ins(SLEEP_WORD);
    rd_chk(ADDR_STATUS, 8'h91);
    chk({7'h00, osc_run}, 8'h00);
    rd_chk(ADDR_WDOG, 8'h00);
    rd_chk(ADDR_PRESCALE, 8'h00);
    ins(12'h325);
    wr(ADDR_CONTROL, 8'h01);
    settle;
    chk({7'h00, instr_ready}, 8'h01);
    rd_chk(6'h05, 8'hD2);
    wr(ADDR_STATUS, 8'h00);
    ins(SLEEP_WORD);
    rd_chk(ADDR_STATUS, 8'h10);
    @(posedge clk);
    pin_change <= 1'b1;
    @(posedge clk);
    pin_change <= 1'b0;
    #1;
    chk({7'h00, instr_ready}, 8'h01);
    rd_chk(ADDR_STATUS, 8'h90);
  endtask : test_sleep

  task test_irq;
    wr(ADDR_IRQ_MASK, 8'h00);
    wr(ADDR_IRQ_STAT, 8'h07);
    ins(12'h325);
    settle;
    chk({7'h00, irq}, 8'h00);
    wr(ADDR_IRQ_MASK, 8'h01);
    settle;
    chk({7'h00, irq}, 8'h01);
    wr(ADDR_IRQ_STAT, 8'h01);
    settle;
    chk({7'h00, irq}, 8'h00);
    wr(6'h30, 8'hFF);
    rd_chk(6'h30, 8'h00);
  endtask : test_irq

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    n_errors = 0;
    comparisons = 0;
    rst_b = 1'b0;
    instr = 12'h000;
    instr_valid = 1'b0;
    pin_change = 1'b0;
    reg_addr = 6'h00;
    reg_wdata = 8'h00;
    reg_write = 1'b0;
    reg_read = 1'b0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    test_rotate;
    test_sleep;
    test_irq;
    report_and_stop;
  end

  // the whole run needs well under a thousand cycles
  initial begin
    #100000;
    n_errors++;
    report_and_stop;
  end
endmodule : rotate_and_sleep_execute_bench

bind rotate_and_sleep_execute rotate_and_sleep_execute_props #(
  .WDOG_BITS(WDOG_BITS), .PRESCALE_BITS(PRESCALE_BITS)
) props_u (
  .clk(clk), .rst_b(rst_b), .instr(instr), .instr_valid(instr_valid),
  .instr_ready(instr_ready), .osc_run(osc_run), .pin_change(pin_change),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
  .reg_read(reg_read), .reg_rdata(reg_rdata), .irq(irq)
);
`default_nettype wire
